/* File: core/menu_params.svh */
// Purpose: Shared constants for the front panel menu controller
// Assumes: 200 MHz reference clock
// Notes:   Times are kept in their own units; cycle counts derive from them
`ifndef MENU_PARAMS_SVH
`define MENU_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ          200000000
`define IDLE_TIMEOUT_S  12
`define DEBOUNCE_US     10000
`define MUTE_US         1000
`define IDLE_CYCLES     (64'(`IDLE_TIMEOUT_S) * 64'(`CLK_HZ))
`define DEBOUNCE_CYCLES ((64'(`DEBOUNCE_US) * 64'(`CLK_HZ)) / 64'd1000000)
`define MUTE_CYCLES     ((64'(`MUTE_US) * 64'(`CLK_HZ)) / 64'd1000000)

// ----------------------------------------
// Value limits
// ----------------------------------------
`define FREQ_MIN_KHZ    22'h1e_8480
`define FREQ_MAX_KHZ    22'h26_25a0
`define GAIN_MAX_DB     6'h32
`define ADDR_MAX        7'h63
`define LVL_MAX_DBM     9'h000
`define LVL_MIN_DBM     9'h1ec

// ----------------------------------------
// Step sizes in kHz and digit weights
// ----------------------------------------
`define STEP0_KHZ       7'h01
`define STEP1_KHZ       7'h0a
`define STEP2_KHZ       7'h64
`define STEP3_KHZ       7'h7d
`define GAIN_COARSE_DB  6'h0a
`define GAIN_FINE_DB    6'h01
`define ADDR_COARSE     7'h0a
`define ADDR_FINE       7'h01

// ----------------------------------------
// Power-on defaults
// ----------------------------------------
`define RST_FREQ_KHZ    22'h1f_4850
`define RST_GAIN_DB     6'h00

`endif

/* File: core/menu_pkg.sv */
// Purpose: Types for the front panel menu controller
// Assumes: Nothing beyond the parameter header
// Notes:   Binary state codes written out
package menu_pkg;

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_EDIT   = 2'b01,
    ST_SAVE   = 2'b10
  } state_t;

  // ----------------------------------------
  // Menu items in panel order
  // ----------------------------------------
  typedef enum logic [2:0] {
    IT_FREQ   = 3'b000,
    IT_GAIN   = 3'b001,
    IT_REMOTE = 3'b010,
    IT_INVERT = 3'b011,
    IT_STEP   = 3'b100,
    IT_EXTREF = 3'b101,
    IT_IFACE  = 3'b110,
    IT_ADDR   = 3'b111
  } item_t;

  // ----------------------------------------
  // Serial interface types
  // ----------------------------------------
  typedef enum logic [1:0] {
    IF_232 = 2'b00,
    IF_422 = 2'b01,
    IF_485 = 2'b10
  } iface_t;

endpackage : menu_pkg

/* File: core/switch_debounce.sv */
// Purpose: Synchronise and debounce one panel switch
// Assumes: Raw input from a pin, asynchronous to ref_clk
// Notes:   One clean press pulse per actuation
`timescale 1ns/1ps
`include "menu_params.svh"

module switch_debounce #(
  parameter logic [31:0] STABLE_CYCLES = 32'(`DEBOUNCE_CYCLES)
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Switch
  input  wire logic raw,
  output logic      level_q,
  output logic      press_q
);

  logic [2:0]  sync_q,  sync_d;
  logic [31:0] cnt_q,   cnt_d;
  logic        level_d;
  logic        press_d;

  // ----------------------------------------
  // Sync chain and stability counter
  // ----------------------------------------
  always_comb begin
    sync_d  = {sync_q[1:0], raw};
    cnt_d   = 32'h0000_0000;
    level_d = level_q;
    press_d = 1'b0;
    if ((sync_q[1] == sync_q[2]) && (sync_q[2] != level_q)) begin
      if (cnt_q >= STABLE_CYCLES - 32'h0000_0001) begin
        level_d = sync_q[2];
        press_d = sync_q[2];
      end else begin
        cnt_d = cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_q  <= 3'h0;
      cnt_q   <= 32'h0000_0000;
      level_q <= 1'b0;
      press_q <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      cnt_q   <= cnt_d;
      level_q <= level_d;
      press_q <= press_d;
    end
  end

  press_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    press_q |=> !press_q) else $error("press pulse longer than one cycle");

endmodule : switch_debounce

/* File: core/idle_timer.sv */
// Purpose: Inactivity timer for the programming sequence
// Assumes: clear pulses on any switch press
// Notes:   expired_q pulses once when the idle time runs out
`timescale 1ns/1ps
`include "menu_params.svh"

module idle_timer #(
  parameter logic [31:0] IDLE_CYCLES = 32'(`IDLE_CYCLES)
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Control
  input  wire logic run,
  input  wire logic clear,
  output logic      expired_q
);

  logic [31:0] cnt_q, cnt_d;
  logic        expired_d;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_comb begin
    cnt_d     = 32'h0000_0000;
    expired_d = 1'b0;
    if (run && !clear) begin
      if (cnt_q >= IDLE_CYCLES - 32'h0000_0001) begin
        expired_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q     <= 32'h0000_0000;
      expired_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      expired_q <= expired_d;
    end
  end

endmodule : idle_timer

/* File: core/front_panel_menu_controller.sv */
// Purpose: Front panel menu controller: switches, menu walk, save prompt
// Assumes: Raw switch pins active high; nv store answers with nv_valid
// Notes:   Frequency held until save; gain applied live while editing
`timescale 1ns/1ps
`include "menu_params.svh"

module front_panel_menu_controller #(
  parameter logic [31:0] IDLE_CYCLES     = 32'(`IDLE_CYCLES),
  parameter logic [31:0] DEBOUNCE_CYCLES = 32'(`DEBOUNCE_CYCLES),
  parameter logic [31:0] MUTE_CYCLES     = 32'(`MUTE_CYCLES)
) (
  // Clock and reset
  input  wire  logic              ref_clk,
  input  wire  logic              resetn,
  // Panel switches, raw pins
  input  wire  logic              exec_btn,
  input  wire  logic              hor_left,
  input  wire  logic              hor_right,
  input  wire  logic              vert_up,
  input  wire  logic              vert_down,
  // Status inputs
  input  wire  logic              pll_unlock,
  input  wire  logic              tx_mute_sel,
  input  wire  logic signed [7:0] rf_level_dbm,
  // Non-volatile restore
  input  wire  logic              nv_valid,
  input  wire  logic [21:0]       nv_freq_khz,
  input  wire  logic [5:0]        nv_gain_db,
  input  wire  logic              nv_remote,
  input  wire  logic              nv_invert,
  input  wire  logic [1:0]        nv_step_sel,
  input  wire  logic              nv_external_reference_item,
  input  wire  menu_pkg::iface_t  nv_iface,
  input  wire  logic [6:0]        nv_node_addr,
  // Committed settings, also the nv write data
  output logic                    nv_write_q,
  output logic [21:0]             freq_khz_q,
  output logic [5:0]              saved_gain_q,
  output logic                    remote_q,
  output logic                    invert_q,
  output logic [1:0]              step_sel_q,
  output logic                    external_reference_item_q,
  output menu_pkg::iface_t        iface_q,
  output logic [6:0]              node_addr_q,
  // Live controls
  output logic [5:0]              gain_db_q,
  output logic                    carrier_mute_q,
  // Display and lamps
  output menu_pkg::state_t        state_q,
  output menu_pkg::item_t         item_q,
  output logic [2:0]              cursor_q,
  output logic                    save_yes_q,
  output logic                    alarm_led_q,
  output logic                    mute_led_q,
  output logic                    remote_led_q
);
  import menu_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] ndig(input item_t it);
    case (it)
      IT_FREQ: ndig = 3'h4;
      IT_GAIN: ndig = 3'h2;
      IT_ADDR: ndig = 3'h2;
      default: ndig = 3'h1;
    endcase
  endfunction : ndig

  function automatic logic [22:0] freq_delta(input logic [1:0] sel, input logic [2:0] k);
    logic [6:0] s;
    logic [9:0] p;
    s = (sel == 2'h0) ? `STEP0_KHZ : (sel == 2'h1) ? `STEP1_KHZ : (sel == 2'h2) ? `STEP2_KHZ : `STEP3_KHZ;
    p = (k == 3'h0) ? 10'h001 : (k == 3'h1) ? 10'h00a : (k == 3'h2) ? 10'h064 : 10'h3e8;
    freq_delta = 23'(s * p);
  endfunction : freq_delta

  // ----------------------------------------
  // Switch conditioning
  // ----------------------------------------
  logic [5:0] raw_sw;
  logic [5:0] lvl_sw;
  logic [5:0] prs_sw;
  assign raw_sw = {pll_unlock, vert_down, vert_up, hor_right, hor_left, exec_btn};

  for (genvar i = 0; i < 6; i++) begin : g_sw
    switch_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .raw     (raw_sw[i]),
      .level_q (lvl_sw[i]),
      .press_q (prs_sw[i])
    );
  end

  logic exec_p, left_p, right_p, up_p, down_p, any_p, tmo;
  assign exec_p  = prs_sw[0];
  assign left_p  = prs_sw[1];
  assign right_p = prs_sw[2];
  assign up_p    = prs_sw[3];
  assign down_p  = prs_sw[4];
  assign any_p   = |prs_sw[4:0];

  idle_timer #(.IDLE_CYCLES(IDLE_CYCLES)) u_idle (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .run       (state_q != ST_NORMAL),
    .clear     (any_p),
    .expired_q (tmo)
  );

  // ----------------------------------------
  // Working copy of settings
  // ----------------------------------------
  logic [21:0] w_freq_q,   w_freq_d;
  logic [5:0]  w_gain_q,   w_gain_d;
  logic        w_remote_q, w_remote_d, w_inv_q, w_inv_d, w_ext_q, w_ext_d;
  logic [1:0]  w_step_q,   w_step_d;
  iface_t      w_if_q,     w_if_d;
  logic [6:0]  w_addr_q,   w_addr_d;
  state_t      state_d;
  item_t       item_d;
  logic [2:0]  cursor_d;
  logic        save_yes_d, commit, revert;
  logic [22:0] f_cand;
  logic [5:0]  g_cand;
  logic [6:0]  a_cand;
  logic [8:0]  lvl;
  logic [2:0]  wk;

  always_comb begin
    state_d    = state_q;
    item_d     = item_q;
    cursor_d   = cursor_q;
    save_yes_d = save_yes_q;
    commit     = 1'b0;
    revert     = 1'b0;
    w_freq_d   = w_freq_q;
    w_gain_d   = w_gain_q;
    w_remote_d = w_remote_q;
    w_inv_d    = w_inv_q;
    w_ext_d    = w_ext_q;
    w_step_d   = w_step_q;
    w_if_d     = w_if_q;
    w_addr_d   = w_addr_q;
    wk         = ndig(item_q) - cursor_q - 3'h1;
    f_cand     = up_p ? {1'b0, w_freq_q} + freq_delta(w_step_q, wk) : {1'b0, w_freq_q} - freq_delta(w_step_q, wk);
    g_cand     = (cursor_q == 3'h0) ? `GAIN_COARSE_DB : `GAIN_FINE_DB;
    g_cand     = up_p ? w_gain_q + g_cand : w_gain_q - g_cand;
    a_cand     = (cursor_q == 3'h0) ? `ADDR_COARSE : `ADDR_FINE;
    a_cand     = up_p ? w_addr_q + a_cand : w_addr_q - a_cand;
    lvl        = {rf_level_dbm[7], rf_level_dbm} + {3'h0, g_cand};
    case (state_q)
      ST_NORMAL: begin
        if (exec_p) begin
          state_d  = ST_EDIT;
          item_d   = IT_FREQ;
          cursor_d = 3'h0;
        end
      end
      ST_EDIT: begin
        if (tmo) begin
          revert = 1'b1;
        end else if (exec_p) begin
          if (cursor_q == ndig(item_q) || item_q == IT_ADDR) begin
            state_d    = ST_SAVE;
            save_yes_d = 1'b1;
          end else begin
            item_d   = item_t'(item_q + 3'h1);
            cursor_d = 3'h0;
          end
        end else if (left_p && cursor_q != 3'h0) begin
          cursor_d = cursor_q - 3'h1;
        end else if (right_p && cursor_q != ndig(item_q)) begin
          cursor_d = cursor_q + 3'h1;
        end else if ((up_p || down_p) && cursor_q != ndig(item_q)) begin
          case (item_q)
            IT_FREQ: begin
              if (f_cand >= {1'b0, `FREQ_MIN_KHZ} && f_cand <= {1'b0, `FREQ_MAX_KHZ}) begin
                w_freq_d = f_cand[21:0];
              end
            end
            IT_GAIN: begin
              if ((up_p ? g_cand > w_gain_q : g_cand < w_gain_q) && g_cand <= `GAIN_MAX_DB &&
                  $signed(lvl) <= $signed(`LVL_MAX_DBM) && $signed(lvl) >= $signed(`LVL_MIN_DBM)) begin
                w_gain_d = g_cand;
              end
            end
            IT_REMOTE: w_remote_d = !w_remote_q;
            IT_INVERT: w_inv_d    = !w_inv_q;
            IT_EXTREF: w_ext_d    = !w_ext_q;
            IT_STEP:   w_step_d   = up_p ? w_step_q + 2'h1 : w_step_q - 2'h1;
            IT_IFACE: begin
              if (up_p) begin
                w_if_d = (w_if_q == IF_485) ? IF_232 : iface_t'(w_if_q + 2'h1);
              end else begin
                w_if_d = (w_if_q == IF_232) ? IF_485 : iface_t'(w_if_q - 2'h1);
              end
            end
            default: begin
              if ((up_p ? a_cand > w_addr_q : a_cand < w_addr_q) && a_cand <= `ADDR_MAX) begin
                w_addr_d = a_cand;
              end
            end
          endcase
        end
      end
      default: begin
        if (tmo) begin
          revert = 1'b1;
        end else if (exec_p) begin
          commit = save_yes_q;
          revert = !save_yes_q;
        end else if (left_p) begin
          save_yes_d = 1'b1;
        end else if (right_p) begin
          save_yes_d = 1'b0;
        end
      end
    endcase
    if (revert || nv_valid) begin
      state_d    = ST_NORMAL;
      w_freq_d   = nv_valid ? nv_freq_khz : freq_khz_q;
      w_gain_d   = nv_valid ? nv_gain_db : saved_gain_q;
      w_remote_d = nv_valid ? nv_remote : remote_q;
      w_inv_d    = nv_valid ? nv_invert : invert_q;
      w_step_d   = nv_valid ? nv_step_sel : step_sel_q;
      w_ext_d    = nv_valid ? nv_external_reference_item : external_reference_item_q;
      w_if_d     = nv_valid ? nv_iface : iface_q;
      w_addr_d   = nv_valid ? nv_node_addr : node_addr_q;
    end
    if (commit) begin
      state_d = ST_NORMAL;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= ST_NORMAL;
      item_q     <= IT_FREQ;
      cursor_q   <= 3'h0;
      save_yes_q <= 1'b1;
      w_freq_q   <= `RST_FREQ_KHZ;
      w_gain_q   <= `RST_GAIN_DB;
      w_remote_q <= 1'b0;
      w_inv_q    <= 1'b0;
      w_step_q   <= 2'h0;
      w_ext_q    <= 1'b0;
      w_if_q     <= IF_232;
      w_addr_q   <= 7'h00;
    end else begin
      state_q    <= state_d;
      item_q     <= item_d;
      cursor_q   <= cursor_d;
      save_yes_q <= save_yes_d;
      w_freq_q   <= w_freq_d;
      w_gain_q   <= w_gain_d;
      w_remote_q <= w_remote_d;
      w_inv_q    <= w_inv_d;
      w_step_q   <= w_step_d;
      w_ext_q    <= w_ext_d;
      w_if_q     <= w_if_d;
      w_addr_q   <= w_addr_d;
    end
  end

  // ----------------------------------------
  // Committed settings, tuner, lamps
  // ----------------------------------------
  logic [31:0] mute_cnt_q, mute_cnt_d;
  logic        upd;
  assign upd = commit || nv_valid;

  always_comb begin
    mute_cnt_d = (mute_cnt_q != 32'h0000_0000) ? mute_cnt_q - 32'h0000_0001 : 32'h0000_0000;
    if (upd && w_freq_d != freq_khz_q) begin
      mute_cnt_d = MUTE_CYCLES;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      nv_write_q     <= 1'b0;
      freq_khz_q     <= `RST_FREQ_KHZ;
      saved_gain_q   <= `RST_GAIN_DB;
      remote_q       <= 1'b0;
      invert_q       <= 1'b0;
      step_sel_q     <= 2'h0;
      external_reference_item_q      <= 1'b0;
      iface_q        <= IF_232;
      node_addr_q    <= 7'h00;
      gain_db_q      <= `RST_GAIN_DB;
      mute_cnt_q     <= 32'h0000_0000;
      carrier_mute_q <= 1'b0;
      alarm_led_q    <= 1'b0;
      mute_led_q     <= 1'b0;
      remote_led_q   <= 1'b0;
    end else begin
      nv_write_q <= commit;
      if (upd) begin
        freq_khz_q   <= w_freq_d;
        saved_gain_q <= w_gain_d;
        remote_q     <= w_remote_d;
        invert_q     <= w_inv_d;
        step_sel_q   <= w_step_d;
        external_reference_item_q    <= w_ext_d;
        iface_q      <= w_if_d;
        node_addr_q  <= w_addr_d;
      end
      gain_db_q      <= w_gain_d;
      mute_cnt_q     <= mute_cnt_d;
      carrier_mute_q <= (mute_cnt_d != 32'h0000_0000);
      alarm_led_q    <= lvl_sw[5];
      mute_led_q     <= tx_mute_sel;
      remote_led_q   <= upd ? w_remote_d : remote_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  enter_exec_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_NORMAL && !exec_p) |=> state_q == ST_NORMAL) else $error("edit entered without execute");
  cursor_right_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_EDIT && !tmo && !exec_p && !left_p && !nv_valid && right_p && cursor_q < ndig(item_q))
    |=> cursor_q == $past(cursor_q) + 3'h1) else $error("cursor did not move right");
  toggle_dir_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_EDIT && item_q == IT_REMOTE && cursor_q == 3'h0 && down_p && !up_p && !exec_p && !tmo
     && !left_p && !right_p && !nv_valid) |=> w_remote_q != $past(w_remote_q)) else $error("toggle missed");
  idle_exit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tmo |=> state_q == ST_NORMAL && w_gain_q == saved_gain_q) else $error("timeout did not revert");
  freq_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(freq_khz_q) |-> $past(upd)) else $error("frequency applied without save");
  mute_on_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(freq_khz_q) |-> carrier_mute_q [*2]) else $error("carrier not muted on retune");
  gain_live_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_EDIT) |=> gain_db_q == w_gain_q) else $error("gain not applied live");
  gain_range_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    gain_db_q <= `GAIN_MAX_DB) else $error("gain above limit");
  alarm_lamp_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    lvl_sw[5] |=> alarm_led_q) else $error("alarm lamp not lit on unlock");
  save_open_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == ST_EDIT && exec_p && !tmo && !nv_valid && item_q == IT_ADDR) |=> state_q == ST_SAVE)
    else $error("save prompt not reached");

endmodule : front_panel_menu_controller

/* File: tb/operator_model.sv */
// Purpose: Panel operator who works the five switches
// Assumes: Switch pins active high, idle low
// Notes:   Each actuation is held and released well past the debounce time
`timescale 1ns/1ps

module operator_model #(
  parameter int HOLD = 12
) (
  // Clock
  input  wire logic ref_clk,
  // Switch pins
  output logic      exec_btn,
  output logic      hor_left,
  output logic      hor_right,
  output logic      vert_up,
  output logic      vert_down
);
  logic [4:0] pins = 5'h0;

  assign {vert_down, vert_up, hor_right, hor_left, exec_btn} = pins;

  task automatic press(input int k);
    @(negedge ref_clk) pins[k] = 1'b1;
    repeat (HOLD) @(negedge ref_clk);
    pins[k] = 1'b0;
    repeat (HOLD) @(negedge ref_clk);
  endtask : press
endmodule : operator_model

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the front panel menu controller
// Assumes: Short idle, debounce and mute counts
// Notes:   Operator model presses switches; bench drives status inputs
`timescale 1ns/1ps
`include "menu_params.svh"

module testbench;
  import menu_pkg::*;
  localparam int E = 0, L = 1, R = 2, U = 3, D = 4;
  logic              ref_clk = 0, resetn = 0, pll_unlock = 0, tx_mute_sel = 0, nv_valid = 0;
  logic              nv_remote = 0, nv_invert = 0, nv_external_reference_item = 0;
  logic signed [7:0] rf_level_dbm = -8'sd30;
  logic              exec_btn, hor_left, hor_right, vert_up, vert_down;
  logic [21:0]       nv_freq_khz = 22'h0, freq_khz_q, prev_f;
  logic [5:0]        nv_gain_db = 6'h0, saved_gain_q, gain_db_q;
  logic [6:0]        nv_node_addr = 7'h0, node_addr_q;
  logic [1:0]        nv_step_sel = 2'h0, step_sel_q;
  logic              nv_write_q, remote_q, invert_q, external_reference_item_q, carrier_mute_q;
  logic              save_yes_q, alarm_led_q, mute_led_q, remote_led_q;
  iface_t            iface_q, nv_iface = IF_232;
  state_t            state_q;
  item_t             item_q;
  logic [2:0]        cursor_q;
  int                n_fail = 0, comparisons = 0, g, rf, n_wr = 0;

  initial forever #2.5 ref_clk = ~ref_clk;

  operator_model u_op (.ref_clk, .exec_btn, .hor_left, .hor_right, .vert_up, .vert_down);

  front_panel_menu_controller #(.IDLE_CYCLES(200), .DEBOUNCE_CYCLES(4), .MUTE_CYCLES(8)) u_front_panel_menu_controller (
    .ref_clk, .resetn, .exec_btn, .hor_left, .hor_right, .vert_up, .vert_down, .pll_unlock, .tx_mute_sel,
    .rf_level_dbm, .nv_valid, .nv_freq_khz, .nv_gain_db, .nv_remote, .nv_invert, .nv_step_sel,
    .nv_external_reference_item, .nv_iface, .nv_node_addr, .nv_write_q, .freq_khz_q, .saved_gain_q, .remote_q,
    .invert_q, .step_sel_q, .external_reference_item_q, .iface_q, .node_addr_q, .gain_db_q, .carrier_mute_q, .state_q, .item_q,
    .cursor_q, .save_yes_q, .alarm_led_q, .mute_led_q, .remote_led_q);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Gain move kept only inside gain and output level limits
  function automatic int gain_step(input int gv, input int d, input int r);
    return (gv + d <= 50 && r + gv + d <= 0 && r + gv + d >= -20) ? gv + d : gv;
  endfunction : gain_step

  // Tuning step of each step-size selection, in kHz
  function automatic int step_khz(input int sel);
    return (sel == 0) ? `STEP0_KHZ : (sel == 1) ? `STEP1_KHZ : (sel == 2) ? `STEP2_KHZ : `STEP3_KHZ;
  endfunction : step_khz

  // Any committed frequency change must come with the mute; store pulses counted
  always @(negedge ref_clk) begin
    if (resetn && freq_khz_q !== prev_f) check("mute", carrier_mute_q, 1);
    if (nv_write_q === 1'b1) n_wr++;
    prev_f <= freq_khz_q;
  end

  initial begin
    repeat (20000) @(negedge ref_clk);
    n_fail++;
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(8));
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    u_op.press(U);
    check("state", state_q, ST_NORMAL);
    u_op.press(E);
    check("state", state_q, ST_EDIT);
    u_op.press(U);
    check("freq", freq_khz_q, `RST_FREQ_KHZ);
    u_op.press(R);
    check("cursor", cursor_q, 1);
    u_op.press(L);
    check("cursor", cursor_q, 0);
    u_op.press(E);
    check("item", item_q, IT_GAIN);
    u_op.press(U);
    check("gain", gain_db_q, 10);
    u_op.press(R);
    u_op.press(U);
    check("gain", gain_db_q, 11);
    check("saved gain", saved_gain_q, 0);
    for (int i = 2; i < 8; i++) begin
      u_op.press(E);
      check("item", item_q, i);
    end
    u_op.press(E);
    check("state", state_q, ST_SAVE);
    u_op.press(E);
    check("freq", freq_khz_q, `RST_FREQ_KHZ + 1000);
    check("saved gain", saved_gain_q, 11);
    check("state", state_q, ST_NORMAL);
    repeat (2) u_op.press(E);
    rf_level_dbm = -8'sd15;
    u_op.press(D);
    check("gain", gain_db_q, 1);
    repeat (2) u_op.press(R);
    u_op.press(E);
    check("state", state_q, ST_SAVE);
    u_op.press(R);
    check("save yes", save_yes_q, 0);
    u_op.press(E);
    check("gain", gain_db_q, 11);
    for (int k = 0; k < 2; k++) begin
      repeat (3) u_op.press(E);
      u_op.press(k ? U : D);
      u_op.press(R);
      repeat (2) u_op.press(E);
      check("remote", remote_q, 1 - k);
      check("remote lamp", remote_led_q, 1 - k);
    end
    for (int p = 0; p < 2; p++) begin
      rf = p ? -31 : -41 + int'($urandom_range(20));
      rf_level_dbm = 8'(rf);
      g = 11;
      repeat (2) u_op.press(E);
      repeat (4) begin
        u_op.press(U);
        g = gain_step(g, 10, rf);
        check("gain", gain_db_q, g);
      end
      repeat (300) @(negedge ref_clk);
      check("state", state_q, ST_NORMAL);
      check("gain", gain_db_q, 11);
    end
    pll_unlock = 1'b1;
    tx_mute_sel = 1'b1;
    repeat (20) @(negedge ref_clk);
    check("alarm", alarm_led_q, 1);
    check("mute lamp", mute_led_q, 1);
    nv_freq_khz = `FREQ_MIN_KHZ + 22'($urandom_range(300000));
    nv_gain_db = 6'($urandom_range(50));
    nv_node_addr = 7'($urandom_range(99));
    nv_step_sel = 2'($urandom_range(3));
    nv_remote = 1'($urandom_range(1));
    nv_invert = 1'($urandom_range(1));
    nv_external_reference_item = 1'($urandom_range(1));
    nv_iface = iface_t'($urandom_range(2));
    nv_valid = 1'b1;
    @(negedge ref_clk) nv_valid = 1'b0;
    @(negedge ref_clk);
    check("nv freq", freq_khz_q, nv_freq_khz);
    check("nv gain", saved_gain_q, nv_gain_db);
    check("nv addr", node_addr_q, nv_node_addr);
    check("nv remote", remote_q, nv_remote);
    check("remote lamp", remote_led_q, nv_remote);
    check("nv step", step_sel_q, nv_step_sel);
    u_op.press(E);
    u_op.press(U);
    repeat (4) u_op.press(R);
    repeat (2) u_op.press(E);
    check("freq step", freq_khz_q, nv_freq_khz + 1000 * step_khz(nv_step_sel));
    // Walk every setting item once, then save at the end of the menu
    repeat (4) u_op.press(E);
    u_op.press(U);
    u_op.press(E);
    u_op.press(U);
    u_op.press(E);
    u_op.press(D);
    u_op.press(E);
    u_op.press(U);
    u_op.press(E);
    u_op.press(U);
    repeat (2) u_op.press(E);
    check("invert", invert_q, !nv_invert);
    check("step", step_sel_q, 2'(nv_step_sel + 1));
    check("external_reference_item", external_reference_item_q, !nv_external_reference_item);
    check("iface", iface_q, (nv_iface == IF_485) ? 0 : nv_iface + 1);
    check("addr", node_addr_q, (nv_node_addr + 10 <= 99) ? nv_node_addr + 10 : nv_node_addr);
    check("nv write", n_wr, 5);
    conclude();
  end
endmodule : testbench
